// [logic/mailbox_device.sv]
// mailbox device end: shared byte buffer, pointers, control bytes, handshake
// assumes: controller on the same clock drives one-cycle wr/rd strobes
//
// Behaviour
// - status bit shows pending device interrupt
// - mask zero hides line, keeps pending
// - host acknowledges after reading whole message
// - source register names buffer, kind, function
// - host writes destination buffer, kind, function
// - destination write ends each host message
// - destination write sets ack; device clears it
// - mailbox bytes, length low, control word high
// - host clears write pointer before writing
// - host clears read pointer before reading
// - data port access increments its pointer
// - random access reloads pointer first
// - pointers readable and writable at 4Ch/48h
`include "mbox_regs.svh"
`timescale 1ns/100ps
module mailbox_device #(
	parameter int DEPTH = 64
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// parallel link to the controller
	mbox_if.dev_mp BUS,
	// device-to-host message offer
	input wire logic DEV_SEND_I,
	input wire mbox_pkg::msg_tag_t DEV_SRC_I,
	input wire logic [7:0] DEV_LEN_I,
	input wire logic [7:0] DEV_CTRL_I,
	output logic DEV_SEND_READY_O,
	// host-to-device message delivery
	output logic HOST_MSG_O,
	output mbox_pkg::msg_tag_t HOST_DEST_O,
	output logic [7:0] HOST_LEN_O,
	output logic [7:0] HOST_CTRL_O,
	input wire logic DEV_ACCEPT_I,
	// device access to the mailbox bytes
	input wire logic DEV_WR_I,
	input wire logic [7:0] DEV_ADDR_I,
	input wire logic [7:0] DEV_WDATA_I,
	output logic [7:0] DEV_RDATA_O
);

	localparam int AW = $clog2(DEPTH);

	// ==========================================================
	// state
	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [7:0] rd_ptr;
		logic [7:0] wr_ptr;
		logic [7:0] ctrl_lo;
		logic [7:0] ctrl_hi;
		mbox_pkg::msg_tag_t dest;
		mbox_pkg::msg_tag_t src;
		logic host_ack;
		logic sta;
		logic mask;
		logic irq;
		logic [7:0] rdata;
		logic [7:0] dev_rdata;
	} state_t;

	state_t st_reg;
	state_t st_next;

	// pointers wrap over the buffer; upper bits are kept for readback only
	function automatic logic [AW-1:0] slot(input logic [7:0] ptr);
		return ptr[AW-1:0];
	endfunction : slot

	// ==========================================================
	// next state
	always_comb
	begin
		st_next = st_reg;

		// device side fills the buffer before offering a message
		if (DEV_WR_I)
		begin
			st_next.mem[slot(DEV_ADDR_I)] = DEV_WDATA_I;
		end
		st_next.dev_rdata = st_reg.mem[slot(DEV_ADDR_I)];

		// host reads, registered one cycle later on rdata
		st_next.rdata = `MBOX_BYTE_RST;
		if (BUS.rd)
		begin
			case (BUS.addr)
				`MBOX_RD_PTR_OFF: st_next.rdata = st_reg.rd_ptr;
				`MBOX_WR_PTR_OFF: st_next.rdata = st_reg.wr_ptr;
				`MBOX_DATA_OFF:
				begin
					st_next.rdata = st_reg.mem[slot(st_reg.rd_ptr)];
					st_next.rd_ptr = st_reg.rd_ptr + 8'h01;
				end
				`MBOX_DEST_OFF:
				begin
					st_next.rdata = `MBOX_BYTE_RST;
					st_next.rdata[`MBOX_HOST_ACK_BIT] = st_reg.host_ack;
				end
				`MBOX_SRC_ACK_OFF: st_next.rdata = st_reg.src;
				`MBOX_CTRL_LO_OFF: st_next.rdata = st_reg.ctrl_lo;
				`MBOX_CTRL_HI_OFF: st_next.rdata = st_reg.ctrl_hi;
				`MBOX_MASK_STA_OFF:
				begin
					st_next.rdata = `MBOX_BYTE_RST;
					st_next.rdata[`MBOX_STA_BIT] = st_reg.sta;
				end
				default: st_next.rdata = `MBOX_BYTE_RST;
			endcase
		end

		// device gives up the host message first, so a new one wins
		if (DEV_ACCEPT_I)
		begin
			st_next.host_ack = 1'b0;
		end

		// host writes; the host wins a same-cycle byte clash with the device
		if (BUS.wr)
		begin
			case (BUS.addr)
				`MBOX_RD_PTR_OFF: st_next.rd_ptr = BUS.wdata;
				`MBOX_WR_PTR_OFF: st_next.wr_ptr = BUS.wdata;
				`MBOX_DATA_OFF:
				begin
					st_next.mem[slot(st_reg.wr_ptr)] = BUS.wdata;
					st_next.wr_ptr = st_reg.wr_ptr + 8'h01;
				end
				`MBOX_DEST_OFF:
				begin
					st_next.dest = BUS.wdata;
					st_next.host_ack = 1'b1;
				end
				`MBOX_SRC_ACK_OFF:
				begin
					if (BUS.wdata[`MBOX_ACK_BIT])
					begin
						st_next.sta = 1'b0;
					end
				end
				`MBOX_CTRL_LO_OFF: st_next.ctrl_lo = BUS.wdata;
				`MBOX_CTRL_HI_OFF: st_next.ctrl_hi = BUS.wdata;
				`MBOX_MASK_STA_OFF: st_next.mask = BUS.wdata[`MBOX_MASK_BIT];
				default:
				begin
				end
			endcase
		end

		// a new offer only once the previous one was acknowledged
		if (DEV_SEND_I && !st_reg.sta)
		begin
			st_next.sta = 1'b1;
			st_next.src = DEV_SRC_I;
			st_next.ctrl_lo = DEV_LEN_I;
			st_next.ctrl_hi = DEV_CTRL_I;
		end

		// masked events stay pending in sta and show once unmasked
		st_next.irq = st_next.sta & st_next.mask;
	end

	// ==========================================================
	// registers
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			st_reg <= '0;
			st_reg.mask <= `MBOX_MASK_RST;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs
	assign BUS.rdata = st_reg.rdata;
	assign BUS.irq = st_reg.irq;
	assign DEV_SEND_READY_O = !st_reg.sta;
	assign HOST_MSG_O = st_reg.host_ack;
	assign HOST_DEST_O = st_reg.dest;
	assign HOST_LEN_O = st_reg.ctrl_lo;
	assign HOST_CTRL_O = st_reg.ctrl_hi;
	assign DEV_RDATA_O = st_reg.dev_rdata;

endmodule : mailbox_device

// [logic/mailbox_host.sv]
// mailbox controller end: AXI4-Lite slave that runs single link accesses
// assumes: device on the same clock answers a read on the next cycle
`include "mbox_regs.svh"
`timescale 1ns/100ps
module mailbox_host (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// AXI4-Lite write channels
	input wire logic [3:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	// AXI4-Lite read channels
	input wire logic [3:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// interrupt
	output logic IRQ_O,
	// parallel link to the device
	mbox_if.host_mp BUS
);

	// ==========================================================
	// state
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [3:0] awaddr;
		logic [31:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] int_status;
		logic [1:0] int_mask;
		mbox_pkg::host_phase_t phase;
		logic [7:0] addr;
		logic [7:0] bdata;
		logic wr;
		logic rd;
		logic [7:0] result;
		logic irq_d;
	} state_t;

	state_t st_reg;
	state_t st_next;
	logic [7:0] cmd_addr;
	logic [7:0] cmd_data;
	mbox_pkg::host_op_t cmd_op;
	logic [1:0] int_evt;

	// fixed-target ops keep the message sequences correct by construction
	function automatic logic [7:0] op_addr(input mbox_pkg::host_op_t op, input logic [7:0] a);
		unique case (op)
			mbox_pkg::OP_ACK: return `MBOX_SRC_ACK_OFF;
			mbox_pkg::OP_SEND: return `MBOX_DEST_OFF;
			mbox_pkg::OP_CLR_WP: return `MBOX_WR_PTR_OFF;
			mbox_pkg::OP_CLR_RP: return `MBOX_RD_PTR_OFF;
			default: return a;
		endcase
	endfunction : op_addr

	function automatic logic [7:0] op_data(input mbox_pkg::host_op_t op, input logic [7:0] d);
		unique case (op)
			mbox_pkg::OP_ACK: return 8'h01;
			mbox_pkg::OP_CLR_WP, mbox_pkg::OP_CLR_RP: return 8'h00;
			default: return d;
		endcase
	endfunction : op_data

	// ==========================================================
	// next state
	always_comb
	begin
		st_next = st_reg;
		cmd_op = mbox_pkg::host_op_t'(st_reg.wdata[`CTL_OP_LSB +: 3]);
		cmd_addr = st_reg.wdata[`CTL_ADDR_LSB +: 8];
		cmd_data = st_reg.wdata[`CTL_DATA_LSB +: 8];
		st_next.wr = 1'b0;
		st_next.rd = 1'b0;
		st_next.irq_d = BUS.irq;
		int_evt = 2'b00;
		int_evt[`CTL_INT_DEV_BIT] = BUS.irq && !st_reg.irq_d;
		int_evt[`CTL_INT_DONE_BIT] = (st_reg.phase == mbox_pkg::PH_CAPTURE) ||
			(st_reg.phase == mbox_pkg::PH_ACCESS && !st_reg.rd);

		// device line rising edge
		if (BUS.irq && !st_reg.irq_d)
		begin
			st_next.int_status[`CTL_INT_DEV_BIT] = 1'b1;
		end

		// link sequencer
		unique case (st_reg.phase)
			mbox_pkg::PH_IDLE:
			begin
			end
			mbox_pkg::PH_ACCESS:
			begin
				if (st_reg.rd)
				begin
					st_next.phase = mbox_pkg::PH_CAPTURE;
				end
				else
				begin
					st_next.phase = mbox_pkg::PH_IDLE;
					st_next.int_status[`CTL_INT_DONE_BIT] = 1'b1;
				end
			end
			mbox_pkg::PH_CAPTURE:
			begin
				st_next.result = BUS.rdata;
				st_next.phase = mbox_pkg::PH_IDLE;
				st_next.int_status[`CTL_INT_DONE_BIT] = 1'b1;
			end
		endcase

		// write channels taken in either order
		if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
		begin
			st_next.aw_got = 1'b1;
			st_next.awaddr = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && S_AXI_WREADY_O)
		begin
			st_next.w_got = 1'b1;
			st_next.wdata = S_AXI_WDATA_I;
		end
		if (st_reg.aw_got && st_reg.w_got)
		begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = `CTL_RESP_OKAY;
			case ({st_reg.awaddr[3:2], 2'b00})
				`CTL_CMD_OFF:
				begin
					// a command while busy is dropped
					if (st_reg.phase == mbox_pkg::PH_IDLE)
					begin
						st_next.phase = mbox_pkg::PH_ACCESS;
						st_next.addr = op_addr(cmd_op, cmd_addr);
						st_next.bdata = op_data(cmd_op, cmd_data);
						st_next.rd = (cmd_op == mbox_pkg::OP_READ);
						st_next.wr = (cmd_op != mbox_pkg::OP_READ);
					end
				end
				`CTL_INT_STATUS_OFF:
					st_next.int_status = st_next.int_status & ~st_reg.wdata[1:0];
				`CTL_INT_MASK_OFF: st_next.int_mask = st_reg.wdata[1:0];
				`CTL_RESULT_OFF:
				begin
				end
				default: st_next.bresp = `CTL_RESP_SLVERR;
			endcase
		end
		// an event in this cycle outlives a same-cycle clear
		st_next.int_status = st_next.int_status | int_evt;
		if (st_reg.bvalid && S_AXI_BREADY_I)
		begin
			st_next.bvalid = 1'b0;
		end

		// read channel
		if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
		begin
			st_next.rvalid = 1'b1;
			st_next.rresp = `CTL_RESP_OKAY;
			st_next.rdata = 32'h0000_0000;
			case ({S_AXI_ARADDR_I[3:2], 2'b00})
				`CTL_CMD_OFF: st_next.rdata = st_reg.wdata;
				`CTL_RESULT_OFF:
				begin
					st_next.rdata[7:0] = st_reg.result;
					st_next.rdata[`CTL_BUSY_BIT] = (st_reg.phase != mbox_pkg::PH_IDLE);
					st_next.rdata[`CTL_IRQ_BIT] = BUS.irq;
				end
				`CTL_INT_STATUS_OFF: st_next.rdata[1:0] = st_reg.int_status;
				`CTL_INT_MASK_OFF: st_next.rdata[1:0] = st_reg.int_mask;
				default: st_next.rresp = `CTL_RESP_SLVERR;
			endcase
		end
		else if (st_reg.rvalid && S_AXI_RREADY_I)
		begin
			st_next.rvalid = 1'b0;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs
	assign S_AXI_AWREADY_O = !st_reg.aw_got && !st_reg.bvalid;
	assign S_AXI_WREADY_O = !st_reg.w_got && !st_reg.bvalid;
	assign S_AXI_BVALID_O = st_reg.bvalid;
	assign S_AXI_BRESP_O = st_reg.bresp;
	assign S_AXI_ARREADY_O = !st_reg.rvalid;
	assign S_AXI_RVALID_O = st_reg.rvalid;
	assign S_AXI_RDATA_O = st_reg.rdata;
	assign S_AXI_RRESP_O = st_reg.rresp;
	assign IRQ_O = |(st_reg.int_status & st_reg.int_mask);
	assign BUS.addr = st_reg.addr;
	assign BUS.wdata = st_reg.bdata;
	assign BUS.wr = st_reg.wr;
	assign BUS.rd = st_reg.rd;

endmodule : mailbox_host

// [logic/mbox_if.sv]
// parallel host link between controller and mailbox device
// assumes: both ends on one clock; strobes are single-cycle
`timescale 1ns/100ps
interface mbox_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic irq;

	modport dev_mp (input addr, input wdata, input wr, input rd, output rdata, output irq);
	modport host_mp (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface : mbox_if

// [logic/mbox_pkg.sv]
// types shared by both ends of the mailbox link
// assumes: nothing beyond the constants header
package mbox_pkg;

	// ==========================================================
	// message tag: source of a device message, destination of a host one
	typedef enum logic [1:0] {BUF0, BUF1, BUF2, BUF_NONE} buf_sel_t;
	typedef struct packed {
		buf_sel_t buffer;
		logic [1:0] kind;
		logic [3:0] func;
	} msg_tag_t;

	// ==========================================================
	// controller commands and sequencer phases
	typedef enum logic [2:0] {
		OP_WRITE, OP_READ, OP_ACK, OP_SEND, OP_CLR_WP, OP_CLR_RP
	} host_op_t;
	typedef enum logic [1:0] {PH_IDLE, PH_ACCESS, PH_CAPTURE} host_phase_t;

endpackage : mbox_pkg

// [logic/mbox_regs.svh]
// offsets, field positions, reset values and response codes of the mailbox link
// assumes: included by bare name wherever a constant is needed
`ifndef MBOX_REGS_SVH
`define MBOX_REGS_SVH

// ==========================================================
// device map on the parallel link
`define MBOX_RD_PTR_OFF 8'h48
`define MBOX_DATA_OFF 8'h4a
`define MBOX_WR_PTR_OFF 8'h4c
`define MBOX_DEST_OFF 8'h50
`define MBOX_SRC_ACK_OFF 8'h58
`define MBOX_CTRL_LO_OFF 8'h60
`define MBOX_CTRL_HI_OFF 8'h61
`define MBOX_MASK_STA_OFF 8'h75
`define MBOX_MASK_BIT 2
`define MBOX_STA_BIT 2
`define MBOX_ACK_BIT 0
`define MBOX_HOST_ACK_BIT 0
`define MBOX_MASK_RST 1'b0
`define MBOX_BYTE_RST 8'h00

// ==========================================================
// controller map on AXI4-Lite (byte addresses)
`define CTL_CMD_OFF 4'h0
`define CTL_RESULT_OFF 4'h4
`define CTL_INT_STATUS_OFF 4'h8
`define CTL_INT_MASK_OFF 4'hc
`define CTL_OP_LSB 0
`define CTL_ADDR_LSB 8
`define CTL_DATA_LSB 16
`define CTL_BUSY_BIT 8
`define CTL_IRQ_BIT 9
`define CTL_INT_DONE_BIT 0
`define CTL_INT_DEV_BIT 1
`define CTL_RESP_OKAY 2'h0
`define CTL_RESP_SLVERR 2'h2

`endif

// [tb/mbox_properties.sv]
// assertions on the parallel mailbox link
// assumes: instantiated beside the link interface, one clock domain
`timescale 1ns/100ps
module mbox_properties (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// link signals
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic irq
);
	// ==========================================================
	// shadow of mask and read pointer, updated as the device does
	logic mask_reg;
	logic [7:0] rp_reg;
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			mask_reg <= 1'b0;
			rp_reg <= 8'h00;
		end
		else
		begin
			if (wr && addr == 8'h75)
				mask_reg <= wdata[2];
			if (wr && addr == 8'h48)
				rp_reg <= wdata;
			else if (rd && addr == 8'h4a)
				rp_reg <= rp_reg + 8'h01;
		end
	end

	// ==========================================================
	// properties
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);
	property p_mask_drops_irq;
		wr && addr == 8'h75 && !wdata[2] |-> ##2 !irq;
	endproperty
	a_mask_drops_irq: assert property (p_mask_drops_irq)
		else $error("irq up after mask clear");
	// irq changes on the same edge as the mask register; the past term only adds slack
	property p_irq_masked;
		irq |-> mask_reg || $past(mask_reg);
	endproperty
	a_irq_masked: assert property (p_irq_masked)
		else $error("irq while masked");
	property p_sta_shows;
		rd && addr == 8'h75 && irq && !$past(wr && addr == 8'h58) |=> rdata[2];
	endproperty
	a_sta_shows: assert property (p_sta_shows)
		else $error("status bit low while pending");
	property p_ack_drops_irq;
		wr && addr == 8'h58 && wdata[0] |-> ##2 !irq;
	endproperty
	a_ack_drops_irq: assert property (p_ack_drops_irq)
		else $error("irq up after acknowledge");
	property p_rp_read;
		rd && addr == 8'h48 |=> rdata == $past(rp_reg);
	endproperty
	a_rp_read: assert property (p_rp_read)
		else $error("read pointer readback wrong");
	property p_ack_one;
		wr && addr == 8'h58 |-> wdata[0];
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("acknowledge written without bit0");
	property p_rd_pulse;
		rd |=> !rd;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse)
		else $error("read strobe longer than one cycle");
	property p_wr_pulse;
		wr |=> !wr;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("write strobe longer than one cycle");
endmodule : mbox_properties

// [tb/testbench.sv]
// self-checking bench: AXI4-Lite master and device user side around both ends
// assumes: controller and device share one clock and reset
`timescale 1ns/100ps
module testbench;
	// ==========================================================
	// signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, r;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, ready, hmsg;
	logic [1:0] bresp, rresp;
	logic send = 1'b0, accept = 1'b0, dwr = 1'b0;
	mbox_pkg::msg_tag_t src = '0;
	mbox_pkg::msg_tag_t dest;
	logic [7:0] len = 8'h00, ctrl = 8'h00, daddr = 8'h00, dwdata = 8'h00, drdata, hlen, hctrl;
	int n_fail = 0;
	int comparisons = 0;

	mbox_if link ();
	mailbox_host u_mailbox_host (.CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdat),
		.S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .IRQ_O(irq), .BUS(link));
	mailbox_device u_mailbox_device (.CLK_I(clk), .RST_I(rst), .BUS(link), .DEV_SEND_I(send),
		.DEV_SRC_I(src), .DEV_LEN_I(len), .DEV_CTRL_I(ctrl), .DEV_SEND_READY_O(ready),
		.HOST_MSG_O(hmsg), .HOST_DEST_O(dest), .HOST_LEN_O(hlen), .HOST_CTRL_O(hctrl),
		.DEV_ACCEPT_I(accept), .DEV_WR_I(dwr), .DEV_ADDR_I(daddr), .DEV_WDATA_I(dwdata),
		.DEV_RDATA_O(drdata));
	mbox_properties u_mbox_properties (.CLK_I(clk), .RST_I(rst), .addr(link.addr),
		.wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .irq(link.irq));

	initial
	begin
		forever #20 clk = ~clk;
	end

	// ==========================================================
	// checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	task automatic give_up(input int n);
		if (n >= 50)
		begin
			check(32'h0, 32'h1);
			report_and_stop();
		end
	endtask : give_up

	// ==========================================================
	// AXI4-Lite master and link commands
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdat <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid && n < 50);
		bready <= 1'b0;
		give_up(n);
		check({30'h0, bresp}, 32'h0);
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid && n < 50);
		rready <= 1'b0;
		give_up(n);
		r = rdat;
		check({30'h0, rresp}, 32'h0);
	endtask : axi_rd

	// one link access, then poll until the controller is idle
	task automatic link_op(input logic [2:0] op, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		axi_wr(4'h0, {8'h00, d, a, 5'h00, op});
		do
		begin
			axi_rd(4'h4);
			n++;
		end
		while (r[8] && n < 50);
		give_up(n);
	endtask : link_op

	task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
		link_op(mbox_pkg::OP_READ, a, 8'h00);
		check({24'h0, r[7:0]}, {24'h0, exp});
	endtask : expect_reg

	task automatic dev_send(input logic [7:0] tag);
		src <= tag;
		len <= 8'h02;
		ctrl <= 8'hc3;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		@(posedge clk);
	endtask : dev_send

	// ==========================================================
	// tests
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		expect_reg(8'h48, 8'h00);
		expect_reg(8'h4c, 8'h00);
		expect_reg(8'h61, 8'h00);
		$display("test reset values finished");
		// only the device-irq event may raise IRQ_O
		axi_wr(4'hc, 32'h2);
		link_op(mbox_pkg::OP_CLR_WP, 8'h4c, 8'h00);
		for (int i = 0; i < 3; i++)
			link_op(mbox_pkg::OP_WRITE, 8'h4a, 8'ha0 + 8'(i));
		expect_reg(8'h4c, 8'h03);
		link_op(mbox_pkg::OP_WRITE, 8'h60, 8'h03);
		link_op(mbox_pkg::OP_WRITE, 8'h61, 8'h5a);
		link_op(mbox_pkg::OP_SEND, 8'h50, 8'h65);
		check({31'h0, hmsg}, 32'h1);
		check({24'h0, dest}, 32'h65);
		check({16'h0, hctrl, hlen}, 32'h5a03);
		expect_reg(8'h50, 8'h01);
		for (int i = 0; i < 3; i++)
		begin
			daddr <= 8'(i);
			repeat (2) @(posedge clk);
			check({24'h0, drdata}, 32'ha0 + i);
		end
		accept <= 1'b1;
		@(posedge clk);
		accept <= 1'b0;
		@(posedge clk);
		check({31'h0, hmsg}, 32'h0);
		expect_reg(8'h50, 8'h00);
		$display("test host message finished");
		for (int i = 0; i < 2; i++)
		begin
			dwr <= 1'b1;
			daddr <= 8'(i);
			dwdata <= 8'hc0 + 8'(i);
			@(posedge clk);
		end
		dwr <= 1'b0;
		dev_send(8'h9a);
		check({31'h0, ready}, 32'h0);
		check({31'h0, irq}, 32'h0);
		expect_reg(8'h75, 8'h04);
		link_op(mbox_pkg::OP_WRITE, 8'h75, 8'h00);
		expect_reg(8'h75, 8'h04);
		link_op(mbox_pkg::OP_WRITE, 8'h75, 8'h04);
		repeat (4) @(posedge clk);
		check({31'h0, irq}, 32'h1);
		expect_reg(8'h75, 8'h04);
		axi_wr(4'hc, 32'h0);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		axi_wr(4'hc, 32'h2);
		axi_wr(4'h8, 32'h3);
		axi_rd(4'h8);
		check(r, 32'h0);
		expect_reg(8'h58, 8'h9a);
		axi_rd(4'h8);
		check(r, 32'h1);
		expect_reg(8'h60, 8'h02);
		expect_reg(8'h61, 8'hc3);
		link_op(mbox_pkg::OP_CLR_RP, 8'h48, 8'h00);
		expect_reg(8'h4a, 8'hc0);
		expect_reg(8'h4a, 8'hc1);
		expect_reg(8'h48, 8'h02);
		link_op(mbox_pkg::OP_WRITE, 8'h48, 8'h01);
		expect_reg(8'h4a, 8'hc1);
		dev_send(8'h11);
		expect_reg(8'h58, 8'h9a);
		link_op(mbox_pkg::OP_ACK, 8'h58, 8'h01);
		check({31'h0, ready}, 32'h1);
		check({31'h0, r[9]}, 32'h0);
		expect_reg(8'h75, 8'h00);
		dev_send(8'h11);
		expect_reg(8'h58, 8'h11);
		$display("test device message finished");
		report_and_stop();
	end
endmodule : testbench
